// ==== rtl/status_sel_pkg.sv ====
// Shared constants for the drive status output selector
package status_sel_pkg;
	localparam int NUM_TERMS  = 2;
	localparam int NUM_FLAGS  = 14;
	localparam int NUM_EVENTS = 4;
	localparam int VAL_W      = 16;
	localparam int CODE_W     = 6;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] TERM_SEL_ADDR  = 8'h00;
	localparam logic [ADDR_W-1:0] DEV_LIM_ADDR   = 8'h04;
	localparam logic [ADDR_W-1:0] OL_LIM_ADDR    = 8'h08;
	localparam logic [ADDR_W-1:0] VLOSS_ADDR     = 8'h0C;
	localparam logic [ADDR_W-1:0] ILOSS_ADDR     = 8'h10;
	localparam logic [ADDR_W-1:0] PID_LOW_ADDR   = 8'h14;
	localparam logic [ADDR_W-1:0] PID_HIGH_ADDR  = 8'h18;
	localparam logic [ADDR_W-1:0] WDOG_ADDR      = 8'h1C;
	localparam logic [ADDR_W-1:0] LOGIC_OP_ADDR  = 8'h20;
	localparam logic [ADDR_W-1:0] FLAGS_ADDR     = 8'h24;
	localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR  = 8'h28;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR  = 8'h2C;
	localparam logic [ADDR_W-1:0] TERM_OUT_ADDR  = 8'h30;

	// Field positions
	localparam int TERM_SEL_STRIDE = 8;
	localparam int LOGIC_OP_W      = 2;

	// Reset values
	localparam logic [VAL_W-1:0]  VAL_RST  = 16'h0000;
	localparam logic [VAL_W-1:0]  WDOG_RST = 16'h03E8;
	localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

	// Terminal option codes
	localparam logic [CODE_W-1:0] OPT_SPEED_DEV = 6'h16;
	localparam logic [CODE_W-1:0] OPT_POS_DONE  = 6'h17;
	localparam logic [CODE_W-1:0] OPT_OVER_FREQ = 6'h18;
	localparam logic [CODE_W-1:0] OPT_SET_FREQ  = 6'h19;
	localparam logic [CODE_W-1:0] OPT_OVERLOAD2 = 6'h1A;
	localparam logic [CODE_W-1:0] OPT_VLOSS     = 6'h1B;
	localparam logic [CODE_W-1:0] OPT_ILOSS     = 6'h1C;
	localparam logic [CODE_W-1:0] OPT_PID2      = 6'h1F;
	localparam logic [CODE_W-1:0] OPT_NET_TO    = 6'h20;
	localparam logic [CODE_W-1:0] OPT_LOGIC1    = 6'h21;
	localparam logic [CODE_W-1:0] OPT_LOGIC2    = 6'h22;
	localparam logic [CODE_W-1:0] OPT_LOGIC3    = 6'h23;
	localparam logic [CODE_W-1:0] OPT_CAP_LIFE  = 6'h27;
	localparam logic [CODE_W-1:0] OPT_FAN_LIFE  = 6'h28;

	// Flag vector bit positions
	localparam int F_SPEED = 0;
	localparam int F_POS   = 1;
	localparam int F_OFREQ = 2;
	localparam int F_SFREQ = 3;
	localparam int F_OL2   = 4;
	localparam int F_VLOSS = 5;
	localparam int F_ILOSS = 6;
	localparam int F_PID   = 7;
	localparam int F_NET   = 8;
	localparam int F_BOOLEAN_OUTPUT_ONE  = 9;
	localparam int F_CAP   = 12;
	localparam int F_FAN   = 13;

	// Interrupt event bits
	localparam int E_NET = 0;
	localparam int E_CAP = 1;
	localparam int E_FAN = 2;
	localparam int E_PID = 3;

	// Boolean operations
	localparam logic [LOGIC_OP_W-1:0] OP_AND = 2'h0;
	localparam logic [LOGIC_OP_W-1:0] OP_OR  = 2'h1;
	localparam logic [LOGIC_OP_W-1:0] OP_XOR = 2'h2;
endpackage : status_sel_pkg

// ==== rtl/drive_status_output_selector.sv ====
// Status flag generation and output terminal selection for a motor drive
//
// What this block does
// - Speed-deviation flag high while speed difference exceeds limit.
// - Positioning-done flag high once positioning has finished.
// - Over-frequency flag high when output on and at or above setpoint.
// - Setpoint-arrival flag high when output on and equal to setpoint.
// - Overload notice flag high while current exceeds notice threshold.
// - Voltage-input loss flag high while voltage input below threshold.
// - Current-input loss flag high while current input below threshold.
// - PID second-stage flag sets while running with process variable low.
// - PID flag clears above high limit or on stop, else holds.
// - Network flag asserts on watchdog expiry; activity restarts it.
// - Each boolean output follows its configured operation result.
// - Capacitor warning asserts once capacitor lifetime is expired.
// - Fan warning asserts once fan lifetime is expired.
module drive_status_output_selector
	import status_sel_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 reset_i,
	input  wire logic                 ce_i,
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic [DATA_W-1:0]    wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [DATA_W-1:0]    rdata_o,
	output logic                      irq_o,
	input  wire logic [VAL_W-1:0]     speed_cmd_i,
	input  wire logic [VAL_W-1:0]     speed_act_i,
	input  wire logic                 pos_done_i,
	input  wire logic                 output_on_i,
	input  wire logic [VAL_W-1:0]     freq_out_i,
	input  wire logic [VAL_W-1:0]     freq_set_i,
	input  wire logic [VAL_W-1:0]     out_current_i,
	input  wire logic [VAL_W-1:0]     volt_in_i,
	input  wire logic [VAL_W-1:0]     curr_in_i,
	input  wire logic [VAL_W-1:0]     process_variable_i,
	input  wire logic                 running_i,
	input  wire logic                 comm_activity_i,
	input  wire logic [2:0]           logic_a_i,
	input  wire logic [2:0]           logic_b_i,
	input  wire logic                 cap_expired_i,
	input  wire logic                 fan_expired_i,
	output logic      [NUM_TERMS-1:0] term_o
);

	// Configuration and interrupt status registers
	logic [CODE_W-1:0]       code_ff [NUM_TERMS];
	logic [VAL_W-1:0]        dev_lim_ff;
	logic [VAL_W-1:0]        ol_lim_ff;
	logic [VAL_W-1:0]        vloss_ff;
	logic [VAL_W-1:0]        iloss_ff;
	logic [VAL_W-1:0]        pid_low_ff;
	logic [VAL_W-1:0]        pid_high_ff;
	logic [VAL_W-1:0]        wdog_ff;
	logic [3*LOGIC_OP_W-1:0] logic_op_ff;
	logic [NUM_EVENTS-1:0]   irq_stat_ff;
	logic [NUM_EVENTS-1:0]   irq_mask_ff;

	// Status state
	logic [NUM_FLAGS-1:0]    flags_ff;
	logic [VAL_W-1:0]        wdog_cnt_ff;
	logic                    net_to_ff;
	logic                    pid_ff;

	// Bus decode
	wire wr_sel   = ce_i & wr_i & (addr_i == TERM_SEL_ADDR);
	wire wr_dev   = ce_i & wr_i & (addr_i == DEV_LIM_ADDR);
	wire wr_ol    = ce_i & wr_i & (addr_i == OL_LIM_ADDR);
	wire wr_vloss = ce_i & wr_i & (addr_i == VLOSS_ADDR);
	wire wr_iloss = ce_i & wr_i & (addr_i == ILOSS_ADDR);
	wire wr_plow  = ce_i & wr_i & (addr_i == PID_LOW_ADDR);
	wire wr_phigh = ce_i & wr_i & (addr_i == PID_HIGH_ADDR);
	wire wr_wdog  = ce_i & wr_i & (addr_i == WDOG_ADDR);
	wire wr_lop   = ce_i & wr_i & (addr_i == LOGIC_OP_ADDR);
	wire wr_istat = ce_i & wr_i & (addr_i == IRQ_STAT_ADDR);
	wire wr_imask = ce_i & wr_i & (addr_i == IRQ_MASK_ADDR);

	// Comparisons
	wire [VAL_W-1:0] speed_diff = (speed_cmd_i >= speed_act_i) ?
		VAL_W'(speed_cmd_i - speed_act_i) : VAL_W'(speed_act_i - speed_cmd_i);
	wire speed_dev  = speed_diff > dev_lim_ff;
	wire over_freq  = output_on_i & (freq_out_i >= freq_set_i);
	wire set_freq   = output_on_i & (freq_out_i == freq_set_i);
	wire overload2  = out_current_i > ol_lim_ff;
	wire volt_loss  = volt_in_i < vloss_ff;
	wire curr_loss  = curr_in_i < iloss_ff;
	wire pid_low    = running_i & (process_variable_i < pid_low_ff);
	wire pid_clr    = ~running_i | (process_variable_i > pid_high_ff);
	wire nxt_pid    = pid_clr ? 1'b0 : (pid_low | pid_ff);
	wire wdog_hit   = ~comm_activity_i & (wdog_cnt_ff >= wdog_ff);
	wire nxt_net_to = ~comm_activity_i & (net_to_ff | wdog_hit);

	// Boolean outputs, one per logic function
	wire [2:0] bool_res;
	genvar gl;
	generate
		for (gl = 0; gl < 3; gl++) begin : g_logic
			wire [LOGIC_OP_W-1:0] op =
				logic_op_ff[gl*LOGIC_OP_W +: LOGIC_OP_W];
			assign bool_res[gl] =
				(op == OP_AND) ? (logic_a_i[gl] & logic_b_i[gl]) :
				(op == OP_OR)  ? (logic_a_i[gl] | logic_b_i[gl]) :
				(op == OP_XOR) ? (logic_a_i[gl] ^ logic_b_i[gl]) : 1'b0;
		end
	endgenerate

	wire [NUM_FLAGS-1:0] nxt_flags = {
		fan_expired_i,
		cap_expired_i,
		bool_res,
		nxt_net_to,
		nxt_pid,
		curr_loss,
		volt_loss,
		overload2,
		set_freq,
		over_freq,
		pos_done_i,
		speed_dev
	};

	// Interrupt events on rising flags
	wire [NUM_EVENTS-1:0] events = {
		nxt_pid & ~pid_ff,
		fan_expired_i & ~flags_ff[F_FAN],
		cap_expired_i & ~flags_ff[F_CAP],
		nxt_net_to & ~net_to_ff
	};
	wire [NUM_EVENTS-1:0] stat_clr =
		wr_istat ? wdata_i[NUM_EVENTS-1:0] : '0;
	wire [NUM_EVENTS-1:0] nxt_irq_stat = (irq_stat_ff & ~stat_clr) | events;

	// Terminal selection
	wire [NUM_TERMS-1:0] nxt_term;
	wire [DATA_W-1:0]    sel_rd;
	genvar gt;
	generate
		for (gt = 0; gt < NUM_TERMS; gt++) begin : g_term
			wire [CODE_W-1:0] c = code_ff[gt];
			assign nxt_term[gt] =
				(c == OPT_SPEED_DEV) ? flags_ff[F_SPEED] :
				(c == OPT_POS_DONE)  ? flags_ff[F_POS] :
				(c == OPT_OVER_FREQ) ? flags_ff[F_OFREQ] :
				(c == OPT_SET_FREQ)  ? flags_ff[F_SFREQ] :
				(c == OPT_OVERLOAD2) ? flags_ff[F_OL2] :
				(c == OPT_VLOSS)     ? flags_ff[F_VLOSS] :
				(c == OPT_ILOSS)     ? flags_ff[F_ILOSS] :
				(c == OPT_PID2)      ? flags_ff[F_PID] :
				(c == OPT_NET_TO)    ? flags_ff[F_NET] :
				(c == OPT_LOGIC1)    ? flags_ff[F_BOOLEAN_OUTPUT_ONE] :
				(c == OPT_LOGIC2)    ? flags_ff[F_BOOLEAN_OUTPUT_ONE+1] :
				(c == OPT_LOGIC3)    ? flags_ff[F_BOOLEAN_OUTPUT_ONE+2] :
				(c == OPT_CAP_LIFE)  ? flags_ff[F_CAP] :
				(c == OPT_FAN_LIFE)  ? flags_ff[F_FAN] : 1'b0;
			assign sel_rd[gt*TERM_SEL_STRIDE +: TERM_SEL_STRIDE] =
				TERM_SEL_STRIDE'(c);
		end
		if (NUM_TERMS*TERM_SEL_STRIDE < DATA_W) begin : g_pad
			assign sel_rd[DATA_W-1:NUM_TERMS*TERM_SEL_STRIDE] = '0;
		end
	endgenerate

	// Read mux
	wire [DATA_W-1:0] rd_mux =
		(addr_i == TERM_SEL_ADDR)  ? sel_rd :
		(addr_i == DEV_LIM_ADDR)   ? DATA_W'(dev_lim_ff) :
		(addr_i == OL_LIM_ADDR)    ? DATA_W'(ol_lim_ff) :
		(addr_i == VLOSS_ADDR)     ? DATA_W'(vloss_ff) :
		(addr_i == ILOSS_ADDR)     ? DATA_W'(iloss_ff) :
		(addr_i == PID_LOW_ADDR)   ? DATA_W'(pid_low_ff) :
		(addr_i == PID_HIGH_ADDR)  ? DATA_W'(pid_high_ff) :
		(addr_i == WDOG_ADDR)      ? DATA_W'(wdog_ff) :
		(addr_i == LOGIC_OP_ADDR)  ? DATA_W'(logic_op_ff) :
		(addr_i == FLAGS_ADDR)     ? DATA_W'(flags_ff) :
		(addr_i == IRQ_STAT_ADDR)  ? DATA_W'(irq_stat_ff) :
		(addr_i == IRQ_MASK_ADDR)  ? DATA_W'(irq_mask_ff) :
		(addr_i == TERM_OUT_ADDR)  ? DATA_W'(term_o) : '0;

	// Option code registers
	generate
		for (gt = 0; gt < NUM_TERMS; gt++) begin : g_code
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					code_ff[gt] <= CODE_RST;
				end else if (wr_sel) begin
					code_ff[gt] <= wdata_i[gt*TERM_SEL_STRIDE +: CODE_W];
				end
			end
		end
	endgenerate

	// Threshold, logic operation and interrupt mask registers
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			dev_lim_ff  <= VAL_RST;
			ol_lim_ff   <= VAL_RST;
			vloss_ff    <= VAL_RST;
			iloss_ff    <= VAL_RST;
			pid_low_ff  <= VAL_RST;
			pid_high_ff <= VAL_RST;
			wdog_ff     <= WDOG_RST;
			logic_op_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			if (wr_dev)   dev_lim_ff  <= wdata_i[VAL_W-1:0];
			if (wr_ol)    ol_lim_ff   <= wdata_i[VAL_W-1:0];
			if (wr_vloss) vloss_ff    <= wdata_i[VAL_W-1:0];
			if (wr_iloss) iloss_ff    <= wdata_i[VAL_W-1:0];
			if (wr_plow)  pid_low_ff  <= wdata_i[VAL_W-1:0];
			if (wr_phigh) pid_high_ff <= wdata_i[VAL_W-1:0];
			if (wr_wdog)  wdog_ff     <= wdata_i[VAL_W-1:0];
			if (wr_lop)   logic_op_ff <= wdata_i[3*LOGIC_OP_W-1:0];
			if (wr_imask) irq_mask_ff <= wdata_i[NUM_EVENTS-1:0];
		end
	end

	// Watchdog counter, restarted by activity
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wdog_cnt_ff <= VAL_RST;
		end else if (ce_i) begin
			if (comm_activity_i) begin
				wdog_cnt_ff <= VAL_RST;
			end else if (!wdog_hit) begin
				wdog_cnt_ff <= VAL_W'(wdog_cnt_ff + 1'b1);
			end
		end
	end

	// Flags, terminals, interrupt, read data
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			flags_ff    <= '0;
			net_to_ff   <= 1'b0;
			pid_ff      <= 1'b0;
			term_o      <= '0;
			irq_stat_ff <= '0;
			irq_o       <= 1'b0;
			rdata_o     <= '0;
		end else if (ce_i) begin
			flags_ff    <= nxt_flags;
			net_to_ff   <= nxt_net_to;
			pid_ff      <= nxt_pid;
			term_o      <= nxt_term;
			irq_stat_ff <= nxt_irq_stat;
			irq_o       <= |(nxt_irq_stat & irq_mask_ff);
			rdata_o     <= rd_i ? rd_mux : '0;
		end
	end

	// Checks
	a_speed_dev_flag: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> flags_ff[F_SPEED] == $past(speed_dev))
		else $error("speed deviation flag wrong");
	a_pos_done_flag: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> flags_ff[F_POS] == $past(pos_done_i))
		else $error("positioning flag wrong");
	a_over_freq_off: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && !output_on_i
		|=> !flags_ff[F_OFREQ] && !flags_ff[F_SFREQ])
		else $error("arrival flag high with output off");
	a_arrival_on: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && output_on_i
		|=> flags_ff[F_OFREQ] == ($past(freq_out_i) >= $past(freq_set_i))
		&& flags_ff[F_SFREQ] == ($past(freq_out_i) == $past(freq_set_i)))
		else $error("arrival flag wrong with output on");
	a_ol_vloss_iloss: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> flags_ff[F_OL2] == ($past(out_current_i) > $past(ol_lim_ff))
		&& flags_ff[F_VLOSS] == ($past(volt_in_i) < $past(vloss_ff))
		&& flags_ff[F_ILOSS] == ($past(curr_in_i) < $past(iloss_ff)))
		else $error("threshold flag wrong");
	a_pid_set_stage: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && running_i && process_variable_i < pid_low_ff
		&& !(process_variable_i > pid_high_ff) |=> flags_ff[F_PID])
		else $error("pid stage not set");
	a_pid_clear_stage: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && (!running_i || process_variable_i > pid_high_ff)
		|=> !flags_ff[F_PID])
		else $error("pid stage not cleared");
	a_pid_hold_stage: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && running_i && process_variable_i >= pid_low_ff
		&& !(process_variable_i > pid_high_ff)
		|=> flags_ff[F_PID] == $past(flags_ff[F_PID]))
		else $error("pid stage not held");
	a_net_act_clear: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && comm_activity_i |=> !flags_ff[F_NET] && wdog_cnt_ff == '0)
		else $error("network flag with activity");
	a_net_expiry: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && !comm_activity_i && wdog_cnt_ff >= wdog_ff
		|=> flags_ff[F_NET])
		else $error("network flag missing on expiry");
	a_net_no_early: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && !comm_activity_i && wdog_cnt_ff < wdog_ff
		&& !flags_ff[F_NET] |=> !flags_ff[F_NET])
		else $error("network flag before expiry");
	a_wdog_count_up: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && !comm_activity_i && wdog_cnt_ff < wdog_ff
		|=> wdog_cnt_ff == $past(wdog_cnt_ff) + 1'b1)
		else $error("watchdog count wrong");
	a_life_warnings: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> flags_ff[F_CAP] == $past(cap_expired_i)
		&& flags_ff[F_FAN] == $past(fan_expired_i))
		else $error("lifetime warning wrong");
	a_logic_and_op: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && logic_op_ff[LOGIC_OP_W-1:0] == OP_AND
		|=> flags_ff[F_BOOLEAN_OUTPUT_ONE] == ($past(logic_a_i[0]) & $past(logic_b_i[0])))
		else $error("boolean output wrong");
	a_logic_or_op: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && logic_op_ff[LOGIC_OP_W +: LOGIC_OP_W] == OP_OR
		|=> flags_ff[F_BOOLEAN_OUTPUT_ONE+1]
		== ($past(logic_a_i[1]) | $past(logic_b_i[1])))
		else $error("second boolean output wrong");
	a_logic_xor_op: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && logic_op_ff[2*LOGIC_OP_W +: LOGIC_OP_W] == OP_XOR
		|=> flags_ff[F_BOOLEAN_OUTPUT_ONE+2]
		== ($past(logic_a_i[2]) ^ $past(logic_b_i[2])))
		else $error("third boolean output wrong");
	a_term_sel_pid: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && code_ff[0] == OPT_PID2
		|=> term_o[0] == $past(flags_ff[F_PID]))
		else $error("terminal selection wrong");
	a_term_sel_net: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && code_ff[1] == OPT_NET_TO
		|=> term_o[1] == $past(flags_ff[F_NET]))
		else $error("second terminal selection wrong");
	a_term_no_code: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && code_ff[0] == CODE_RST |=> !term_o[0])
		else $error("terminal high with no function");

endmodule : drive_status_output_selector

// ==== dv/term_reader.sv ====
// Model of external control equipment that polls the output terminals
module term_reader
	import status_sel_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic [NUM_TERMS-1:0] term_i,
	output logic      [NUM_TERMS-1:0] seen_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Terminals are sampled once per clock, as a polling controller would
	always_ff @(posedge mclk_i) begin
		seen_o <= term_i;
	end
endmodule : term_reader

// ==== dv/tb_top.sv ====
// Self-checking testbench for the drive status output selector
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("ERROR %s exp %0h got %0h", nm, e, g); \
	end \
end
module tb_top
	import status_sel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 mclk_i = 1'b0;
	logic                 reset_i = 1'b1;
	logic                 ce_i = 1'b1;
	logic [ADDR_W-1:0]    addr_i = '0;
	logic [DATA_W-1:0]    wdata_i = '0;
	logic                 wr_i = 1'b0;
	logic                 rd_i = 1'b0;
	logic [DATA_W-1:0]    rdata_o;
	logic                 irq_o;
	logic [VAL_W-1:0]     speed_cmd_i = '0, speed_act_i = '0;
	logic                 pos_done_i = 1'b0, output_on_i = 1'b0;
	logic [VAL_W-1:0]     freq_out_i = '0, freq_set_i = '0;
	logic [VAL_W-1:0]     out_current_i = '0, volt_in_i = '0;
	logic [VAL_W-1:0]     curr_in_i = '0, process_variable_i = '0;
	logic                 running_i = 1'b0, comm_activity_i = 1'b1;
	logic [2:0]           logic_a_i = '0, logic_b_i = '0;
	logic                 cap_expired_i = 1'b0, fan_expired_i = 1'b0;
	logic [NUM_TERMS-1:0] term_o, seen;
	logic [31:0]          seed = 32'h00000029;
	logic [31:0]          r, r2, r3, r4, d;
	logic [VAL_W-1:0]     lim_dev, lim_ol, lim_v, lim_i;
	logic [5:0]           ops;
	logic [13:0]          ef;
	int                   err_count = 0;
	int                   total_checks = 0;
	logic [CODE_W-1:0]    codes [14] = '{OPT_SPEED_DEV, OPT_POS_DONE,
		OPT_OVER_FREQ, OPT_SET_FREQ, OPT_OVERLOAD2, OPT_VLOSS, OPT_ILOSS,
		OPT_PID2, OPT_NET_TO, OPT_LOGIC1, OPT_LOGIC2, OPT_LOGIC3,
		OPT_CAP_LIFE, OPT_FAN_LIFE};
	int                   pr [7] = '{1, 1, 1, 1, 1, 1, 0};
	int                   pv [7] = '{100, 99, 200, 201, 150, 50, 50};
	logic                 pe [7] = '{0, 1, 1, 0, 0, 1, 0};

	always #5 mclk_i = ~mclk_i;

	drive_status_output_selector uut (.mclk_i(mclk_i), .reset_i(reset_i),
		.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.speed_cmd_i(speed_cmd_i), .speed_act_i(speed_act_i),
		.pos_done_i(pos_done_i), .output_on_i(output_on_i),
		.freq_out_i(freq_out_i), .freq_set_i(freq_set_i),
		.out_current_i(out_current_i), .volt_in_i(volt_in_i),
		.curr_in_i(curr_in_i), .process_variable_i(process_variable_i),
		.running_i(running_i), .comm_activity_i(comm_activity_i),
		.logic_a_i(logic_a_i), .logic_b_i(logic_b_i),
		.cap_expired_i(cap_expired_i), .fan_expired_i(fan_expired_i),
		.term_o(term_o));

	term_reader reader (.mclk_i(mclk_i), .term_i(term_o), .seen_o(seen));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected combinational flags from the present inputs and settings
	function automatic logic [13:0] exp_flags();
		int          dv;
		logic [13:0] f;
		dv = int'(speed_cmd_i) - int'(speed_act_i);
		f = '0;
		f[0] = ((dv < 0) ? -dv : dv) > int'(lim_dev);
		f[1] = pos_done_i;
		f[2] = output_on_i && (freq_out_i >= freq_set_i);
		f[3] = output_on_i && (freq_out_i == freq_set_i);
		f[4] = out_current_i > lim_ol;
		f[5] = volt_in_i < lim_v;
		f[6] = curr_in_i < lim_i;
		for (int k = 0; k < 3; k++) begin
			case (ops[2*k +: 2])
				2'h0: f[9+k] = logic_a_i[k] & logic_b_i[k];
				2'h1: f[9+k] = logic_a_i[k] | logic_b_i[k];
				2'h2: f[9+k] = logic_a_i[k] ^ logic_b_i[k];
				default: f[9+k] = 1'b0;
			endcase
		end
		f[12] = cap_expired_i;
		f[13] = fan_expired_i;
		return f;
	endfunction : exp_flags

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask : bus_rd

	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : settle

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	initial begin
		#300000;
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge mclk_i);
		reset_i <= 1'b0;
		settle(1);
		`CHK("term_rst", 2'h0, term_o)
		`CHK("irq_rst", 1'b0, irq_o)
		bus_rd(WDOG_ADDR, d);
		`CHK("wdog_rst", 32'h000003E8, d)
		bus_rd(8'h3C, d);
		`CHK("unmapped", 32'h00000000, d)
		r = rnd();
		lim_dev = {7'h00, r[8:0]};
		lim_ol = r[31:16];
		r = rnd();
		lim_v = r[15:0];
		lim_i = r[31:16];
		ops = r[5:0];
		bus_wr(DEV_LIM_ADDR, {16'h0000, lim_dev});
		bus_wr(OL_LIM_ADDR, {16'h0000, lim_ol});
		bus_wr(VLOSS_ADDR, {16'h0000, lim_v});
		bus_wr(ILOSS_ADDR, {16'h0000, lim_i});
		bus_wr(LOGIC_OP_ADDR, {26'h0, ops});
		for (int i = 0; i < 42; i++) begin
			r = rnd();
			r2 = rnd();
			r3 = rnd();
			r4 = rnd();
			bus_wr(TERM_SEL_ADDR,
				{18'h0, codes[(i+5)%14], 2'h0, codes[i%14]});
			@(posedge mclk_i);
			speed_cmd_i <= {1'b0, r[14:0]};
			speed_act_i <= (i % 3 == 0) ? {1'b0, r[14:0]} + lim_dev
				: r2[15:0];
			freq_set_i <= r2[31:16];
			freq_out_i <= (i % 3 == 0) ? r2[31:16] : r3[15:0];
			out_current_i <= (i % 3 == 0) ? lim_ol : r3[31:16];
			volt_in_i <= (i % 3 == 0) ? lim_v : r[31:16];
			curr_in_i <= r4[31:16];
			{logic_b_i, logic_a_i, fan_expired_i} <= r4[6:0];
			{cap_expired_i, output_on_i, pos_done_i} <= r4[9:7];
			settle(3);
			ef = exp_flags();
			`CHK("term", {ef[(i+5)%14], ef[i%14]}, seen)
			`CHK("irq_masked", 1'b0, irq_o)
			bus_rd(FLAGS_ADDR, d);
			`CHK("flags", {18'h0, ef}, d)
			`CHK("flags_b", {18'h0, ef}, d)
			`CHK("flags_c", {18'h0, ef}, d)
		end
		ops = 6'h24;
		bus_wr(LOGIC_OP_ADDR, {26'h0, ops});
		for (int j = 0; j < 4; j++) begin
			r = rnd();
			@(posedge mclk_i);
			{logic_b_i, logic_a_i} <= r[5:0];
			settle(2);
			ef = exp_flags();
			bus_rd(FLAGS_ADDR, d);
			`CHK("logic_ops", {18'h0, ef}, d)
		end
		bus_wr(IRQ_STAT_ADDR, 32'h0000000F);
		bus_wr(IRQ_MASK_ADDR, 32'h00000008);
		bus_wr(PID_LOW_ADDR, 32'h00000064);
		bus_wr(PID_HIGH_ADDR, 32'h000000C8);
		bus_wr(TERM_SEL_ADDR, {18'h0, OPT_NET_TO, 2'h0, OPT_PID2});
		for (int s = 0; s < 7; s++) begin
			@(posedge mclk_i);
			running_i <= pr[s][0];
			process_variable_i <= VAL_W'(pv[s]);
			settle(3);
			`CHK("pid_term", pe[s], seen[0])
			if (s == 1) begin
				`CHK("irq_pid", 1'b1, irq_o)
				bus_wr(IRQ_STAT_ADDR, 32'h00000008);
				settle(2);
				`CHK("irq_clr", 1'b0, irq_o)
				bus_rd(IRQ_MASK_ADDR, d);
				`CHK("mask", 32'h00000008, d)
			end
		end
		bus_wr(WDOG_ADDR, 32'h00000014);
		@(posedge mclk_i);
		comm_activity_i <= 1'b0;
		settle(10);
		`CHK("net_early", 1'b0, seen[1])
		settle(20);
		`CHK("net_late", 1'b1, seen[1])
		bus_rd(TERM_OUT_ADDR, d);
		`CHK("term_rd", 32'h00000002, d)
		@(posedge mclk_i);
		comm_activity_i <= 1'b1;
		settle(4);
		`CHK("net_clear", 1'b0, seen[1])
		@(posedge mclk_i);
		ce_i <= 1'b0;
		comm_activity_i <= 1'b0;
		bus_wr(WDOG_ADDR, 32'h00000001);
		settle(30);
		`CHK("ce_frozen", 1'b0, seen[1])
		@(posedge mclk_i);
		ce_i <= 1'b1;
		bus_rd(WDOG_ADDR, d);
		`CHK("ce_wr_ignored", 32'h00000014, d)
		settle(4);
		`CHK("ce_count_held", 1'b0, seen[1])
		bus_rd(TERM_SEL_ADDR, d);
		`CHK("sel_rd", {18'h0, OPT_NET_TO, 2'h0, OPT_PID2}, d)
		wrap_up();
	end
endmodule : tb_top
